// ---- core/sprx_front.v ----
// Purpose: Input selection, pin mode, truncation and powerdown control of the receiver.
// Assumes: All inputs synchronous to clk; decoder delivers one 24-bit word per subframe.
// Notes:   Register port is a plain write/read strobe interface from the control port.
`timescale 1ns/1ps
`include "sprx_map.vh"

// What this block does
// - One of eight serial inputs is routed to the decoder, input n chosen by select value n.
// - An eight-bit circuit-type field has bit 0 for input 0 up to bit 7 for input 7.
// - A circuit-type bit of 0 means CMOS receiver, 1 means comparator, all ones after reset.
// - With the upper-inputs-as-outputs bit set, inputs 4 to 7 become CMOS general outputs.
// - With truncation disable clear words are cut to the indicated length, set they pass whole.
// - The high-rate bit limits the receiver to 96kHz when 0 and allows 192kHz when 1, reset 1.
// - The powerdown bit enables the receiver at 0 and disables it at 1, reset 1.
// - A powerdown request takes effect only after the current frame ends.
// - Words are always 24 bits; truncation clears bits beyond a shorter indicated length.
module sprx_front
(
    input wire clk, // 50 MHz system clock
    input wire srst, // Synchronous reset, active high
    input wire reg_wr, // Register write strobe
    input wire reg_rd, // Register read strobe
    input wire [7:0] reg_addr, // Register address
    input wire [7:0] reg_wdata, // Register write data
    output reg [7:0] reg_rdata_q, // Read data, valid cycle after reg_rd
    input wire [7:0] serial_input_in, // Serial inputs 0..7 as sampled
    input wire [3:0] gpo_value, // Values for upper pins when outputs
    output reg [3:0] general_output_pin_q, // Upper pin output values
    output reg [3:0] general_output_oe_n_q, // Upper pin enables, low drives
    output reg [7:0] input_circuit_type_bits_q, // 1 comparator, 0 CMOS per input
    output reg decoder_in_q, // Selected serial stream to decoder
    output reg high_rate_support_q, // 192 kHz allowed
    output reg rx_enable_q, // Receiver running
    input wire frame_end, // Decoder pulse at last subframe of a frame
    input wire word_valid, // Decoder word strobe
    output reg word_ready_q, // FIFO can take a word
    input wire [23:0] word_data, // Decoded 24-bit word
    input wire [4:0] word_len, // Indicated length 0 when not given
    output reg out_valid_q, // Output word valid
    input wire out_ready, // Consumer takes output word
    output reg [23:0] out_data_q // Output word
);
    reg [7:0] insel_q;
    reg [7:0] cktype_q;
    reg [7:0] rxcfg_q;
    reg [7:0] power_down_control_q;
    reg [23:0] trunc_d;
    reg rx_enable_d;
    reg word_ready_d;
    reg word_take;
    wire [2:0] mux_sel;
    wire gpo_en;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [23:0] fifo_out_data;
    wire fifo_pop;

    // Mask of the bits kept for an indicated length; 0 or 24 and above keep all
    function [23:0] trunc_mask;
        input [4:0] len;
        integer i;
        begin
            trunc_mask = 24'h000000;
            for (i = 0; i < 24; i = i + 1)
            begin
                if ((len == 5'h00) || (len >= `SPRX_FULL_WL) || (i >= (24 - len)))
                begin
                    trunc_mask[i] = 1'b1;
                end
            end
        end
    endfunction

    assign mux_sel = insel_q[`SPRX_INSEL_MSB:`SPRX_INSEL_LSB];
    assign gpo_en = rxcfg_q[`SPRX_GPO_BIT];
    // Head word moves to the output stage when that stage is free or being emptied
    assign fifo_pop = fifo_out_valid && (!out_valid_q || out_ready);

    // Writes land at the taking edge and reads answer one cycle later
    // Unmapped addresses are ignored on write and read back as zero
    always @(posedge clk)
    begin
        if (srst)
        begin
            insel_q <= `SPRX_INSEL_RST;
            cktype_q <= `SPRX_CKTYPE_RST;
            rxcfg_q <= `SPRX_RXCFG_RST;
            power_down_control_q <= `SPRX_POWER_DOWN_CONTROL_RST;
            reg_rdata_q <= 8'h00;
        end
        else
        begin
            if (reg_wr)
            begin
                case (reg_addr)
                    `SPRX_ADDR_INSEL: insel_q <= {5'h00, reg_wdata[2:0]};
                    `SPRX_ADDR_CKTYPE: cktype_q <= reg_wdata;
                    `SPRX_ADDR_RXCFG: rxcfg_q <= reg_wdata;
                    `SPRX_ADDR_POWER_DOWN_CONTROL: power_down_control_q <= reg_wdata;
                    default: ;
                endcase
            end
            if (reg_rd)
            begin
                case (reg_addr)
                    `SPRX_ADDR_INSEL: reg_rdata_q <= insel_q;
                    `SPRX_ADDR_CKTYPE: reg_rdata_q <= cktype_q;
                    `SPRX_ADDR_RXCFG: reg_rdata_q <= rxcfg_q;
                    `SPRX_ADDR_POWER_DOWN_CONTROL: reg_rdata_q <= {power_down_control_q[7:1], !rx_enable_q};
                    default: reg_rdata_q <= 8'h00;
                endcase
            end
        end
    end

    // A cleared request enables at once, a set one waits for the end of the frame
    always @*
    begin
        rx_enable_d = rx_enable_q;
        if (!power_down_control_q[`SPRX_PD_BIT])
        begin
            rx_enable_d = 1'b1;
        end
        else if (frame_end)
        begin
            rx_enable_d = 1'b0;
        end
    end

    // Bit 0 of the powerdown read shows the applied state, bit 1 the request
    always @(posedge clk)
    begin
        if (srst)
        begin
            rx_enable_q <= 1'b0;
        end
        else
        begin
            rx_enable_q <= rx_enable_d;
        end
    end

    // Ready leaves a flip-flop, so it is offered only when a slot is sure to be free;
    // after a take it drops for one cycle, which keeps a full buffer from losing words
    always @*
    begin
        word_take = word_valid && word_ready_q;
        word_ready_d = rx_enable_d && fifo_in_ready && !word_take;
    end

    // Pin controls and decoder feed are registered so that each output leaves a flip-flop
    always @(posedge clk)
    begin
        if (srst)
        begin
            decoder_in_q <= 1'b0;
            input_circuit_type_bits_q <= `SPRX_CKTYPE_RST;
            high_rate_support_q <= 1'b1;
            general_output_pin_q <= 4'h0;
            general_output_oe_n_q <= 4'hf;
        end
        else
        begin
            // Upper inputs read as idle when they are outputs
            decoder_in_q <= (gpo_en && mux_sel[2]) ? 1'b0 : serial_input_in[mux_sel];
            input_circuit_type_bits_q <= cktype_q;
            high_rate_support_q <= rxcfg_q[`SPRX_HIRATE_BIT];
            general_output_pin_q <= gpo_en ? gpo_value : 4'h0;
            general_output_oe_n_q <= gpo_en ? 4'h0 : 4'hf;
        end
    end

    // Truncation keeps the top len bits of the 24-bit word
    always @*
    begin
        if (rxcfg_q[`SPRX_TRUNC_DIS_BIT])
        begin
            trunc_d = word_data;
        end
        else
        begin
            trunc_d = word_data & trunc_mask(word_len);
        end
    end

    // Words enter the buffer only through the valid/ready handshake
    sprx_fifo #(
        .WIDTH(24),
        .DEPTH(`SPRX_FIFO_DEPTH),
        .AW(`SPRX_FIFO_AW)
    ) u_fifo (
        .clk(clk),
        .srst(srst),
        .in_valid(word_take),
        .in_ready(fifo_in_ready),
        .in_data(trunc_d),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data)
    );

    // Output stage holds its word until the consumer takes it
    always @(posedge clk)
    begin
        if (srst)
        begin
            word_ready_q <= 1'b0;
            out_valid_q <= 1'b0;
            out_data_q <= 24'h000000;
        end
        else
        begin
            word_ready_q <= word_ready_d;
            if (fifo_pop)
            begin
                out_valid_q <= 1'b1;
                out_data_q <= fifo_out_data;
            end
            else if (out_ready)
            begin
                out_valid_q <= 1'b0;
            end
        end
    end
endmodule // sprx_front

// ---- core/sprx_map.vh ----
// Purpose: Register map and field layout of the receiver input front end.
// Assumes: Plain Verilog-2005, included by its bare name.
// Notes:   Offsets are the register addresses of the control port.
`ifndef SPRX_MAP_VH
`define SPRX_MAP_VH

`define SPRX_ADDR_INSEL     8'h08
`define SPRX_ADDR_CKTYPE    8'h09
`define SPRX_ADDR_RXCFG     8'h1c
`define SPRX_ADDR_POWER_DOWN_CONTROL     8'h1e

`define SPRX_INSEL_RST      8'h00
`define SPRX_CKTYPE_RST     8'hff
`define SPRX_RXCFG_RST      8'h80
`define SPRX_POWER_DOWN_CONTROL_RST      8'h02

`define SPRX_INSEL_LSB      0
`define SPRX_INSEL_MSB      2
`define SPRX_GPO_BIT        5
`define SPRX_TRUNC_DIS_BIT  6
`define SPRX_HIRATE_BIT     7
`define SPRX_PD_BIT         1

`define SPRX_FULL_WL        5'h18
`define SPRX_FIFO_DEPTH     16
`define SPRX_FIFO_AW        4

`endif

// ---- core/sprx_fifo.v ----
// Purpose: Word FIFO with valid/ready on both sides.
// Assumes: Single clock, synchronous active-high reset.
// Notes:   Storage is a flip-flop array addressed by index.
`timescale 1ns/1ps
module sprx_fifo #(
    parameter WIDTH = 24,
    parameter DEPTH = 16,
    parameter AW = 4
)
(
    input wire clk, // System clock
    input wire srst, // Synchronous reset
    input wire in_valid, // Write request
    output wire in_ready, // Room available
    input wire [WIDTH-1:0] in_data, // Write word
    output wire out_valid, // Word available
    input wire out_ready, // Consumer takes word
    output wire [WIDTH-1:0] out_data // Head word
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW-1:0] wr_q;
    reg [AW-1:0] rd_q;
    reg [AW:0] cnt_q;
    wire push;
    wire pop;

    assign in_ready = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign out_data = mem_q[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always @(posedge clk)
    begin
        if (push)
        begin
            mem_q[wr_q] <= in_data;
        end
    end

    always @(posedge clk)
    begin
        if (srst)
        begin
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
            begin
                wr_q <= wr_q + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop)
            begin
                rd_q <= rd_q + {{(AW-1){1'b0}}, 1'b1};
            end
            if (push && !pop)
            begin
                cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
            end
            else if (pop && !push)
            begin
                cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule // sprx_fifo

// ---- tb/sprx_front_asserts.sv ----
// Purpose: Port assertions for the receiver front end.
// Assumes: One clock, srst synchronous active high.
// Notes: Select, pin mode and powerdown request are mirrored from writes.
`timescale 1ns/1ps
module sprx_front_asserts (
    input wire clk, // Clock
    input wire srst, // Reset
    input wire reg_wr, // Write
    input wire [7:0] reg_addr, // Address
    input wire [7:0] reg_wdata, // Data
    input wire [7:0] serial_input_in, // Lines
    input wire [3:0] general_output_oe_n_q, // Enables
    input wire [7:0] input_circuit_type_bits_q, // Modes
    input wire decoder_in_q, // Stream
    input wire high_rate_support_q, // Rate
    input wire rx_enable_q, // Running
    input wire frame_end, // Frame end
    input wire out_valid_q, // Valid
    input wire out_ready, // Ready
    input wire [23:0] out_data_q // Word
);
    reg [2:0] sel_q;
    reg gpo_q;
    reg pd_q;
    reg exp_q;
    always @(posedge clk)
    begin
        if (srst)
        begin
            sel_q <= 3'h0;
            gpo_q <= 1'b0;
            pd_q <= 1'b1;
            exp_q <= 1'b0;
        end
        else
        begin
            exp_q <= serial_input_in[sel_q] & ~(gpo_q & sel_q[2]);
            if (reg_wr && reg_addr == 8'h08)
                sel_q <= reg_wdata[2:0];
            if (reg_wr && reg_addr == 8'h1c)
                gpo_q <= reg_wdata[5];
            if (reg_wr && reg_addr == 8'h1e)
                pd_q <= reg_wdata[1];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    property p_mux; decoder_in_q == exp_q; endproperty
    a_mux: assert property (p_mux)
        else $error("wrong input routed");
    property p_ckt;
        reg_wr && reg_addr == 8'h09 |-> ##2 input_circuit_type_bits_q == $past(reg_wdata, 2);
    endproperty
    a_ckt: assert property (p_ckt)
        else $error("circuit type not written");
    property p_oe; general_output_oe_n_q == {4{~$past(gpo_q)}}; endproperty
    a_oe: assert property (p_oe)
        else $error("pin enable wrong");
    property p_rate; reg_wr && reg_addr == 8'h1c |-> ##2 high_rate_support_q == $past(reg_wdata[7], 2); endproperty
    a_rate: assert property (p_rate)
        else $error("rate bit wrong");
    property p_pdon; reg_wr && reg_addr == 8'h1e && !reg_wdata[1] |-> ##2 rx_enable_q; endproperty
    a_pdon: assert property (p_pdon)
        else $error("receiver not enabled");
    property p_pdhold; rx_enable_q && !frame_end |=> rx_enable_q; endproperty
    a_pdhold: assert property (p_pdhold)
        else $error("stopped before frame end");
    property p_pdoff; frame_end && pd_q |=> !rx_enable_q; endproperty
    a_pdoff: assert property (p_pdoff)
        else $error("not stopped at frame end");
    property p_hold; out_valid_q && !out_ready |=> out_valid_q && $stable(out_data_q); endproperty
    a_hold: assert property (p_hold)
        else $error("output word not held");
endmodule // sprx_front_asserts
bind sprx_front sprx_front_asserts u_chk (.clk, .srst, .reg_wr, .reg_addr, .reg_wdata, .serial_input_in,
    .general_output_oe_n_q, .input_circuit_type_bits_q, .decoder_in_q, .high_rate_support_q, .rx_enable_q,
    .frame_end, .out_valid_q, .out_ready, .out_data_q);

// ---- tb/sprx_src_model.sv ----
// Purpose: Audio source feeding lines and decoded words.
// Assumes: Waits for ready, one word in flight.
// Notes: Data lines toggle while no word is offered.
`timescale 1ns/1ps
module sprx_src_model (
    input wire clk, // Clock
    input wire srst, // Reset
    input wire en, // Send words
    input wire [31:0] rnd, // Random source
    input wire word_ready_q, // Device ready
    output reg [7:0] serial_input_in, // Lines
    output reg word_valid, // Offered
    output reg [23:0] word_data, // Word
    output reg [4:0] word_len // Length
);
    always @(posedge clk)
    begin
        serial_input_in <= rnd[7:0];
        if (!word_valid && en && !srst)
        begin
            word_valid <= 1'b1;
            word_data <= rnd[31:8];
            word_len <= rnd[4:0];
        end
        else if (srst || word_ready_q || !word_valid)
        begin
            word_valid <= 1'b0;
            word_data <= ~rnd[31:8];
        end
    end
endmodule // sprx_src_model

// ---- tb/tb_top.sv ----
// Purpose: Self-checking bench of the receiver front end.
// Assumes: 50 MHz clock, 16-cycle reset.
// Notes: A queue model predicts every output word.
`timescale 1ns/1ps
module tb_top;
    reg clk, srst, reg_wr, reg_rd, out_ready, frame_end, en, tdis, s;
    reg [7:0] reg_addr, reg_wdata;
    reg [3:0] gpo_value;
    reg [31:0] rnd = 32'ha9f1;
    reg [1:0] om;
    wire [7:0] reg_rdata_q, serial_input_in, ckt;
    wire [3:0] oe_n, pin;
    wire dec, hr, rx_en, word_valid, word_ready_q, out_valid_q;
    wire [23:0] word_data, out_data_q;
    wire [4:0] word_len;
    integer fails, compares, n, g;
    reg [23:0] q[$];
    sprx_front dut (.clk, .srst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata_q, .serial_input_in,
        .gpo_value, .general_output_pin_q(pin), .general_output_oe_n_q(oe_n), .input_circuit_type_bits_q(ckt),
        .decoder_in_q(dec), .high_rate_support_q(hr), .rx_enable_q(rx_en), .frame_end, .word_valid,
        .word_ready_q, .word_data, .word_len, .out_valid_q, .out_ready, .out_data_q);
    sprx_src_model src (.clk, .srst, .en, .rnd, .word_ready_q, .serial_input_in, .word_valid, .word_data,
        .word_len);
    function [31:0] lfsr(input [31:0] v);
        lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function [23:0] trunc(input [23:0] d, input [4:0] l);
        trunc = (!tdis && l != 0 && l < 24) ? d & (24'hffffff << (24 - l)) : d;
    endfunction
    task chk(input [23:0] got, input [23:0] exp);
    begin
        compares = compares + 1;
        if (got !== exp)
        begin
            fails = fails + 1;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    end
    endtask
    task wr(input [7:0] a, input [7:0] d);
    begin
        @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge clk) reg_wr <= 1'b0;
        @(posedge clk);
        #1;
    end
    endtask
    task rd(input [7:0] a, input [7:0] e);
    begin
        @(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clk) reg_rd <= 1'b0;
        #1 chk(reg_rdata_q, e);
    end
    endtask
    task end_sim;
    begin
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    end
    endtask
    always @(posedge clk)
    begin
        rnd <= lfsr(rnd);
        out_ready <= om[1] | (om[0] & rnd[9]);
        if (word_valid && word_ready_q)
            q.push_back(trunc(word_data, word_len));
        if (out_valid_q && out_ready)
            chk(out_data_q, q.pop_front());
    end
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial
    begin
        repeat (5000) @(posedge clk);
        fails = fails + 1;
        end_sim;
    end
    initial
    begin
        {fails, compares, srst} = {32'h0, 32'h0, 1'b1};
        {reg_wr, reg_rd, frame_end, en, tdis, om, reg_addr, reg_wdata, gpo_value} = 27'h0;
        repeat (16) @(posedge clk);
        {srst, gpo_value} <= {1'b0, rnd[3:0]};
        @(posedge clk);
        #1 chk(oe_n, 4'hf);
        chk({ckt, hr, rx_en}, 10'h3fe);
        rd(8'h08, 8'h00);
        rd(8'h09, 8'hff);
        rd(8'h1c, 8'h80);
        rd(8'h1e, 8'h03);
        rd(8'h33, 8'h00);
        $display("reset test done");
        for (g = 0; g < 2; g = g + 1)
        begin
            wr(g ? 8'h20 : 8'h80, 8'h0);
            wr(8'h1c, g ? 8'h20 : 8'h80);
            chk({oe_n, hr}, g ? 5'h00 : 5'h1f);
            chk(pin, g ? gpo_value : 4'h0);
            for (n = 0; n < 8; n = n + 1)
            begin
                wr(8'h08, n[7:0]);
                wr(8'h09, 8'h01 << n);
                chk(ckt, 8'h01 << n);
                @(negedge clk) s = serial_input_in[n];
                @(negedge clk) chk(dec, (g && n > 3) ? 1'b0 : s);
            end
        end
        $display("mux test done");
        wr(8'h1e, 8'h00);
        chk(rx_en, 1'b1);
        for (g = 0; g < 2; g = g + 1)
        begin
            tdis = g[0];
            wr(8'h1c, {1'b1, g[0], 6'h0});
            {en, om} <= 3'h4;
            repeat (60) @(posedge clk);
            #1 chk({word_ready_q, q.size() == 17}, 2'h1);
            om <= 2'd1;
            repeat (300) @(posedge clk);
            {en, om} <= 3'h2;
            repeat (40) @(posedge clk);
            #1 chk({q.size(), out_valid_q}, 0);
        end
        $display("stream test done");
        wr(8'h1e, 8'h02);
        repeat (8) @(posedge clk);
        #1 chk(rx_en, 1'b1);
        rd(8'h1e, 8'h02);
        @(posedge clk) frame_end <= 1'b1;
        @(posedge clk) frame_end <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk(rx_en, 1'b0);
        rd(8'h1e, 8'h03);
        $display("powerdown test done");
        end_sim;
    end
endmodule // tb_top
